// *** hdl/modbus_pkg.sv ***
// shared constants for the modbus register access slave
package modbus_pkg;
    // ------------------------------------------------------------
    // function codes and exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] FN_RD_HOLD  = 8'h03;
    localparam logic [7:0] FN_RD_IN    = 8'h04;
    localparam logic [7:0] FN_WR_ONE   = 8'h06;
    localparam logic [7:0] FN_WR_MANY  = 8'h10;
    localparam logic [7:0] FN_EXC_STAT = 8'h07;
    localparam logic [7:0] FN_DIAG     = 8'h08;
    localparam logic [7:0] FN_EV_CNT   = 8'h0b;
    localparam logic [7:0] FN_EV_LOG   = 8'h0c;
    localparam logic [7:0] FN_SLAVE_ID = 8'h11;
    localparam logic [7:0] EXC_NONE    = 8'h00;
    localparam logic [7:0] EXC_FUNC    = 8'h01;
    localparam logic [7:0] EXC_ADDR    = 8'h02;
    localparam logic [7:0] EXC_VALUE   = 8'h03;
    // ------------------------------------------------------------
    // block layout and reset bases
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 16;
    localparam int          MV_OFF_W     = 6;
    localparam int          CTL_REGS     = 25;
    localparam logic [15:0] MV_BASE_RST  = 16'h03e8;
    localparam logic [15:0] CTL_BASE_RST = 16'h07d0;
    localparam logic [15:0] MV_LEN       = 16'h0030;
    localparam logic [15:0] CTL_LEN      = 16'h0019;
    localparam logic [15:0] SA_FIRST_OFF = 16'h0010;
    localparam logic [15:0] SA_RST_OFF   = 16'h0012;
    localparam logic [15:0] SA_LAST_OFF  = 16'h0017;
    localparam logic [15:0] CTL_MV_BASE  = 16'h0000;
    localparam logic [15:0] CTL_CTL_BASE = 16'h0001;
    localparam logic [15:0] CTL_PASSWORD = 16'h0002;
    localparam logic [15:0] CTL_CID_FIRST = 16'h0003;
    localparam logic [15:0] CTL_CID_LAST = 16'h000a;
    localparam logic [15:0] RD_QTY_MAX   = 16'h007d;
    localparam logic [15:0] WR_QTY_MAX   = 16'h007b;
    localparam logic [16:0] ADDR_SPACE   = 17'h10000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_XFER  = 2'b11,
        ST_DONE  = 2'b10
    } state_t;
    typedef enum logic [1:0] {
        BLK_NONE = 2'b00,
        BLK_MV   = 2'b01,
        BLK_CTL  = 2'b10
    } blk_t;
endpackage

// *** hdl/modbus_register_access_slave.sv ***
// modbus function handler for the metered-values and device-control blocks
//
// Overview of operation
// - codes 0x03 and 0x04 read the same register space identically
// - codes 0x06 and 0x10 write registers, subject to per-register limits
// - metered-values block sits at 1000..1047 after reset
// - device-control block sits at 2000..2024 after reset
// - block bases are control registers; decoding follows them
// - the password register reads as zero; other restricted registers read back their value
// - reads outside both blocks get an exception
// - 0x06 refused on every register of the metered block
// - customer id elements writable by 0x06 once password gives privilege
// - a one-register 0x10 write acts exactly like 0x06
// - in metered block only summed counter sets accept 0x10
// - some writes need the correct password first
// - counter writing may be disabled; fewer than four counters possible
// - 0x07 and 0x08 partly supported, serial line only
// - 0x0b, 0x0c and 0x11 partly supported, serial line only
// - summed counter one never accepts a new value
`timescale 1ns/1ps
`default_nettype none
module modbus_register_access_slave #(
    parameter int          SA_COUNT    = 4,
    parameter bit          SA_WRITE_EN = 1'b1,
    parameter logic [15:0] PASSWORD    = 16'h5a5a  // arbitrary value
) (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_b,
    input  wire logic                              serial_line,
    input  wire logic                              req_valid,
    input  wire logic [7:0]                        req_func,
    input  wire logic [modbus_pkg::ADDR_W-1:0]     req_addr,
    input  wire logic [modbus_pkg::ADDR_W-1:0]     req_qty,
    output logic                                   req_ready,
    input  wire logic                              wd_valid,
    input  wire logic [modbus_pkg::DATA_W-1:0]     wd_data,
    output logic                                   wd_ready,
    output logic [modbus_pkg::MV_OFF_W-1:0]        mv_rd_off,
    input  wire logic [modbus_pkg::DATA_W-1:0]     mv_rd_data,
    output logic                                   mv_wr_en,
    output logic [modbus_pkg::MV_OFF_W-1:0]        mv_wr_off,
    output logic [modbus_pkg::DATA_W-1:0]          mv_wr_data,
    output logic                                   rsp_word_valid,
    output logic [modbus_pkg::DATA_W-1:0]          rsp_word,
    output logic                                   rsp_done,
    output logic [7:0]                             rsp_exc_code,
    output logic                                   rsp_diag,
    output logic                                   priv_ok
);
    import modbus_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t             state_ff;
    logic [7:0]         func_ff;
    logic [15:0]        start_ff;
    logic [15:0]        qty_ff;
    logic [15:0]        idx_ff;
    logic [15:0]        cnt_ff;
    logic               phase_ff;
    logic [7:0]         exc_ff;
    logic               diag_ff;
    logic               priv_ff;
    logic [15:0]        ctl_ff [CTL_REGS];
    logic               req_ready_ff;
    logic               wd_ready_ff;
    logic [5:0]         mv_rd_off_ff;
    logic               mv_wr_en_ff;
    logic [5:0]         mv_wr_off_ff;
    logic [15:0]        mv_wr_data_ff;
    logic               rsp_word_valid_ff;
    logic [15:0]        rsp_word_ff;
    logic               rsp_done_ff;
    logic [7:0]         rsp_exc_code_ff;
    logic               rsp_diag_ff;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // which block an address falls in, given programmed bases
    function automatic blk_t blk_of(input logic [15:0] a,
                                    input logic [15:0] mb,
                                    input logic [15:0] cb);
        blk_t k;
        k = BLK_NONE;
        if (a >= mb && (a - mb) < MV_LEN) begin
            k = BLK_MV;
        end else if (a >= cb && (a - cb) < CTL_LEN) begin
            k = BLK_CTL;
        end
        return k;
    endfunction

    // may this register be written by this request
    function automatic logic wr_ok(input blk_t k, input logic [15:0] o,
                                   input logic [7:0] f, input logic p);
        logic [15:0] n;
        logic ok;
        n = ((o - SA_FIRST_OFF) >> 1) + 16'h0001;
        ok = 1'b0;
        if (k == BLK_MV) begin
            ok = (f == FN_WR_MANY) && SA_WRITE_EN
                 && o >= SA_RST_OFF && o <= SA_LAST_OFF
                 && n <= 16'(SA_COUNT);
        end else if (k == BLK_CTL) begin
            if (o == CTL_MV_BASE || o == CTL_CTL_BASE) begin
                ok = p;
            end else if (o >= CTL_CID_FIRST && o <= CTL_CID_LAST) begin
                ok = p;
            end else begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    logic        take;
    logic        is_rd;
    logic        is_w1;
    logic        is_wm;
    logic        is_diag;
    logic        is_wr;
    logic [15:0] qty_eff;
    logic [16:0] end_addr;
    blk_t        cur_blk;
    logic [15:0] cur_off;
    logic        last;
    logic        pair_bad;
    logic        wd_take;

    // request classification and current-address decode
    always_comb begin
        take     = req_valid && req_ready_ff;
        is_rd    = req_func == FN_RD_HOLD || req_func == FN_RD_IN;
        is_w1    = req_func == FN_WR_ONE;
        is_wm    = req_func == FN_WR_MANY;
        is_diag  = req_func == FN_EXC_STAT || req_func == FN_DIAG
                || req_func == FN_EV_CNT || req_func == FN_EV_LOG
                || req_func == FN_SLAVE_ID;
        qty_eff  = is_w1 ? 16'h0001 : req_qty;
        end_addr = {1'b0, req_addr} + {1'b0, qty_eff};
        is_wr    = func_ff == FN_WR_ONE || func_ff == FN_WR_MANY;
        cur_blk  = blk_of(idx_ff, ctl_ff[0], ctl_ff[1]);
        if (cur_blk == BLK_MV) begin
            cur_off = idx_ff - ctl_ff[0];
        end else begin
            cur_off = idx_ff - ctl_ff[1];
        end
        last     = cnt_ff == qty_ff - 16'h0001;
        // summed counters are two-register sets, written whole
        pair_bad = cur_blk == BLK_MV
                && ((cnt_ff == 16'h0000 && cur_off[0])
                 || (last && !cur_off[0]));
        wd_take  = wd_valid && wd_ready_ff;
    end

    // ------------------------------------------------------------
    // sequencer: idle, check whole range, transfer, done
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            func_ff  <= 8'h00;
            start_ff <= 16'h0000;
            qty_ff   <= 16'h0000;
            idx_ff   <= 16'h0000;
            cnt_ff   <= 16'h0000;
            phase_ff <= 1'b0;
            exc_ff   <= EXC_NONE;
            diag_ff  <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (take) begin
                        func_ff  <= req_func;
                        start_ff <= req_addr;
                        qty_ff   <= qty_eff;
                        idx_ff   <= req_addr;
                        cnt_ff   <= 16'h0000;
                        phase_ff <= 1'b0;
                        exc_ff   <= EXC_NONE;
                        diag_ff  <= 1'b0;
                        state_ff <= ST_DONE;
                        if (!(is_rd || is_w1 || is_wm
                              || (is_diag && serial_line))) begin
                            exc_ff <= EXC_FUNC;
                        end else if (is_diag) begin
                            diag_ff <= 1'b1;
                        end else if (qty_eff == 16'h0000
                                     || (is_rd && qty_eff > RD_QTY_MAX)
                                     || (is_wm && qty_eff > WR_QTY_MAX)) begin
                            exc_ff <= EXC_VALUE;
                        end else if (end_addr > ADDR_SPACE) begin
                            exc_ff <= EXC_ADDR;
                        end else begin
                            state_ff <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    // every address is vetted before anything moves
                    if (cur_blk == BLK_NONE) begin
                        exc_ff   <= EXC_ADDR;
                        state_ff <= ST_DONE;
                    end else if (is_wr && (pair_bad
                                 || !wr_ok(cur_blk, cur_off, func_ff, priv_ff))) begin
                        exc_ff   <= EXC_ADDR;
                        state_ff <= ST_DONE;
                    end else if (last) begin
                        idx_ff   <= start_ff;
                        cnt_ff   <= 16'h0000;
                        state_ff <= ST_XFER;
                    end else begin
                        idx_ff <= idx_ff + 16'h0001;
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                ST_XFER: begin
                    if (is_wr ? wd_take : phase_ff) begin
                        idx_ff <= idx_ff + 16'h0001;
                        cnt_ff <= cnt_ff + 16'h0001;
                        if (last) begin
                            state_ff <= ST_DONE;
                        end
                    end
                    phase_ff <= !is_wr && !phase_ff;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // device-control registers and privilege
    // ------------------------------------------------------------
    logic ctl_wr;
    assign ctl_wr = state_ff == ST_XFER && is_wr && wd_take && cur_blk == BLK_CTL;

    // control register storage; bases reset to their default places
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < CTL_REGS; i++) begin
                ctl_ff[i] <= 16'h0000;
            end
            ctl_ff[0] <= MV_BASE_RST;
            ctl_ff[1] <= CTL_BASE_RST;
        end else if (ctl_wr) begin
            ctl_ff[cur_off[4:0]] <= wd_data;
        end
    end

    // password entry grants or withdraws privilege
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            priv_ff <= 1'b0;
        end else if (ctl_wr && cur_off == CTL_PASSWORD) begin
            priv_ff <= wd_data == PASSWORD;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_ready_ff      <= 1'b0;
            wd_ready_ff       <= 1'b0;
            mv_rd_off_ff      <= 6'h00;
            mv_wr_en_ff       <= 1'b0;
            mv_wr_off_ff      <= 6'h00;
            mv_wr_data_ff     <= 16'h0000;
            rsp_word_valid_ff <= 1'b0;
            rsp_word_ff       <= 16'h0000;
            rsp_done_ff       <= 1'b0;
            rsp_exc_code_ff   <= EXC_NONE;
            rsp_diag_ff       <= 1'b0;
        end else begin
            req_ready_ff <= state_ff == ST_DONE
                         || (state_ff == ST_IDLE && !take);
            // data words are accepted only once the range is vetted
            if (state_ff == ST_CHECK) begin
                wd_ready_ff <= is_wr && last && cur_blk != BLK_NONE
                            && !pair_bad
                            && wr_ok(cur_blk, cur_off, func_ff, priv_ff);
            end else if (wd_take && last) begin
                wd_ready_ff <= 1'b0;
            end
            // summed counter writes go to the metering engine
            mv_wr_en_ff <= state_ff == ST_XFER && is_wr && wd_take
                        && cur_blk == BLK_MV;
            if (wd_take) begin
                mv_wr_off_ff  <= cur_off[5:0];
                mv_wr_data_ff <= wd_data;
            end
            // reads: address the engine, then return the word
            if (state_ff == ST_XFER && !is_wr && !phase_ff) begin
                mv_rd_off_ff <= cur_off[5:0];
            end
            rsp_word_valid_ff <= state_ff == ST_XFER && !is_wr && phase_ff;
            if (state_ff == ST_XFER && !is_wr && phase_ff) begin
                if (cur_blk == BLK_MV) begin
                    rsp_word_ff <= mv_rd_data;
                end else if (cur_off == CTL_PASSWORD) begin
                    rsp_word_ff <= 16'h0000;
                end else begin
                    rsp_word_ff <= ctl_ff[cur_off[4:0]];
                end
            end
            rsp_done_ff <= state_ff == ST_DONE;
            if (state_ff == ST_DONE) begin
                rsp_exc_code_ff <= exc_ff;
                rsp_diag_ff     <= diag_ff;
            end
        end
    end

    assign req_ready      = req_ready_ff;
    assign wd_ready       = wd_ready_ff;
    assign mv_rd_off      = mv_rd_off_ff;
    assign mv_wr_en       = mv_wr_en_ff;
    assign mv_wr_off      = mv_wr_off_ff;
    assign mv_wr_data     = mv_wr_data_ff;
    assign rsp_word_valid = rsp_word_valid_ff;
    assign rsp_word       = rsp_word_ff;
    assign rsp_done       = rsp_done_ff;
    assign rsp_exc_code   = rsp_exc_code_ff;
    assign rsp_diag       = rsp_diag_ff;
    assign priv_ok        = priv_ff;
endmodule
`default_nettype wire

// *** test/metering_engine_model.sv ***
// behavioural metering engine serving the metered-values block
`timescale 1ns/1ps
`default_nettype none
module metering_engine_model (
    input  wire logic                            sys_clk,
    input  wire logic [modbus_pkg::MV_OFF_W-1:0] mv_rd_off,
    output logic      [modbus_pkg::DATA_W-1:0]   mv_rd_data,
    input  wire logic                            mv_wr_en,
    input  wire logic [modbus_pkg::MV_OFF_W-1:0] mv_wr_off,
    input  wire logic [modbus_pkg::DATA_W-1:0]   mv_wr_data
);
    import modbus_pkg::*;
    logic [DATA_W-1:0] mem [0:47];
    // known pattern so each word is traceable to its offset
    initial begin
        for (int i = 0; i < 48; i++) begin
            mem[i] = 16'h1000 + 16'(i);
        end
    end
    // unread offsets give a changed value, never a stale one
    assign mv_rd_data = (mv_rd_off < 6'h30) ? mem[mv_rd_off] : ~mem[mv_rd_off[4:0]];
    // counter presets land in the engine
    always @(posedge sys_clk) begin
        if (mv_wr_en) begin
            mem[mv_wr_off] <= mv_wr_data;
        end
    end
endmodule
`default_nettype wire

// *** test/slave_asserts.sv ***
// port-level checks for the register access slave
`timescale 1ns/1ps
`default_nettype none
module slave_asserts (
    input wire logic                            sys_clk,
    input wire logic                            rst_b,
    input wire logic                            serial_line,
    input wire logic                            req_valid,
    input wire logic [7:0]                      req_func,
    input wire logic [modbus_pkg::ADDR_W-1:0]   req_qty,
    input wire logic                            req_ready,
    input wire logic                            wd_valid,
    input wire logic                            wd_ready,
    input wire logic                            mv_wr_en,
    input wire logic [modbus_pkg::MV_OFF_W-1:0] mv_wr_off,
    input wire logic                            rsp_word_valid,
    input wire logic                            rsp_done,
    input wire logic [7:0]                      rsp_exc_code,
    input wire logic                            rsp_diag,
    input wire logic                            priv_ok
);
    import modbus_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // request classes at the take edge
    wire take   = req_valid && req_ready;
    wire wtake  = wd_valid && wd_ready;
    wire diag_f = req_func inside {FN_EXC_STAT, FN_DIAG, FN_EV_CNT, FN_EV_LOG, FN_SLAVE_ID};
    wire rd_f   = req_func inside {FN_RD_HOLD, FN_RD_IN};
    wire good_f = diag_f || rd_f || (req_func inside {FN_WR_ONE, FN_WR_MANY});
    property p_bad_code;
        take && !good_f |-> ##2 rsp_done && rsp_exc_code == EXC_FUNC;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("unknown code not refused");
    property p_diag_serial;
        take && diag_f && !serial_line |-> ##2 rsp_done && rsp_exc_code == EXC_FUNC && !rsp_diag;
    endproperty
    a_diag_serial: assert property (p_diag_serial) else $error("diag code off serial line");
    property p_rd_qty;
        take && rd_f && (req_qty == 16'h0000 || req_qty > RD_QTY_MAX) |-> ##2 rsp_done && rsp_exc_code == EXC_VALUE;
    endproperty
    a_rd_qty: assert property (p_rd_qty) else $error("bad read count not refused");
    property p_quiet;
        take && !good_f |=> (!wd_ready && !rsp_word_valid && !mv_wr_en) [*2];
    endproperty
    a_quiet: assert property (p_quiet) else $error("refused request had effects");
    property p_sa_one;
        mv_wr_en |-> mv_wr_off >= SA_RST_OFF[5:0] && mv_wr_off <= SA_LAST_OFF[5:0];
    endproperty
    a_sa_one: assert property (p_sa_one) else $error("metered write outside counters 2-4");
    property p_wr_cause;
        mv_wr_en |-> $past(wtake);
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("metered write without a word");
    property p_priv_cause;
        $changed(priv_ok) |-> $past(wtake) || $past(wtake, 2);
    endproperty
    a_priv_cause: assert property (p_priv_cause) else $error("privilege moved without a write");
    property p_diag_ok;
        rsp_done && rsp_diag |-> rsp_exc_code == EXC_NONE && !wd_ready;
    endproperty
    a_diag_ok: assert property (p_diag_ok) else $error("diag accept with exception");
endmodule
bind modbus_register_access_slave slave_asserts u_asserts (
    .sys_clk(sys_clk), .rst_b(rst_b), .serial_line(serial_line), .req_valid(req_valid),
    .req_func(req_func), .req_qty(req_qty), .req_ready(req_ready), .wd_valid(wd_valid),
    .wd_ready(wd_ready), .mv_wr_en(mv_wr_en), .mv_wr_off(mv_wr_off), .rsp_done(rsp_done),
    .rsp_word_valid(rsp_word_valid), .rsp_exc_code(rsp_exc_code), .rsp_diag(rsp_diag), .priv_ok(priv_ok)
);
`default_nettype wire

// *** test/modbus_register_access_slave_bench.sv ***
// self-checking bench for the register access slave
`timescale 1ns/1ps
`default_nettype none
module modbus_register_access_slave_bench;
    import modbus_pkg::*;
    logic                sys_clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                serial_line = 1'b0;
    logic                req_valid = 1'b0;
    logic                wd_valid = 1'b0;
    logic [7:0]          req_func = 8'h00;
    logic [ADDR_W-1:0]   req_addr = 16'h0000;
    logic [ADDR_W-1:0]   req_qty = 16'h0000;
    logic [DATA_W-1:0]   wd_data = 16'h0000;
    logic                req_ready, wd_ready, mv_wr_en, rsp_word_valid, rsp_done, rsp_diag, priv_ok;
    logic [MV_OFF_W-1:0] mv_rd_off, mv_wr_off;
    logic [DATA_W-1:0]   mv_rd_data, mv_wr_data, rsp_word;
    logic [7:0]          rsp_exc_code, exc;
    logic [DATA_W-1:0]   rdq[$], wdq[$];
    int                  mismatches = 0, n_compared = 0, cycles = 0;
    modbus_register_access_slave uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .serial_line(serial_line), .req_valid(req_valid),
        .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty), .req_ready(req_ready),
        .wd_valid(wd_valid), .wd_data(wd_data), .wd_ready(wd_ready), .mv_rd_off(mv_rd_off),
        .mv_rd_data(mv_rd_data), .mv_wr_en(mv_wr_en), .mv_wr_off(mv_wr_off), .mv_wr_data(mv_wr_data),
        .rsp_word_valid(rsp_word_valid), .rsp_word(rsp_word), .rsp_done(rsp_done),
        .rsp_exc_code(rsp_exc_code), .rsp_diag(rsp_diag), .priv_ok(priv_ok));
    metering_engine_model engine (.sys_clk(sys_clk), .mv_rd_off(mv_rd_off), .mv_rd_data(mv_rd_data),
        .mv_wr_en(mv_wr_en), .mv_wr_off(mv_wr_off), .mv_wr_data(mv_wr_data));
    // 125 MHz clock and hang guard
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one request with its write words; gathers read words and the code
    task automatic xact(input logic [7:0] f, input logic [15:0] a, q, input int nw);
        int i;
        bit rt, wt, fin;
        i = 0;
        fin = 0;
        rdq = {};
        req_func = f;
        req_addr = a;
        req_qty = q;
        req_valid = 1'b1;
        wd_valid = (nw > 0);
        wd_data = (nw > 0) ? wdq[0] : 16'hffff;
        for (int k = 0; k < 600 && !fin; k++) begin
            rt = req_ready;
            wt = wd_ready && wd_valid;
            @(negedge sys_clk);
            if (rt) req_valid = 1'b0;
            if (wt) begin
                i++;
                wd_valid = (i < nw);
                wd_data = (i < nw) ? wdq[i] : ~wd_data;
            end
            if (rsp_word_valid === 1'b1) rdq.push_back(rsp_word);
            if (rsp_done === 1'b1) begin
                exc = rsp_exc_code;
                fin = 1'b1;
            end
        end
        wd_valid = 1'b0;
        @(negedge sys_clk);
        if (!fin) chk("rsp_done", 16'h0000, 16'h0001);
    endtask
    task automatic rd(input logic [15:0] a, q);
        xact(FN_RD_HOLD, a, q, 0);
    endtask
    task automatic wr(input logic [7:0] f, input logic [15:0] a, v0, v1, input int n, input logic [7:0] ex);
        wdq = '{v0, v1};
        xact(f, a, 16'(n), n);
        chk("wr_exc", 16'(exc), 16'(ex));
    endtask
    task automatic t_read();
        logic [15:0] ta [9] = '{16'h03e7, 16'h0417, 16'h0417, 16'h0418, 16'h07e8, 16'h07e9, 16'hffff, 16'h03e8, 16'h03e8};
        logic [15:0] tq [9] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0000, 16'h007e};
        logic [7:0]  te [9] = '{EXC_ADDR, EXC_NONE, EXC_ADDR, EXC_ADDR, EXC_NONE, EXC_ADDR, EXC_ADDR, EXC_VALUE, EXC_VALUE};
        rd(16'h07d0, 16'h0002);
        chk("mv_base", rdq[0], 16'h03e8);
        chk("ctl_base", rdq[1], 16'h07d0);
        for (int f = 0; f < 2; f++) begin
            xact(f ? FN_RD_IN : FN_RD_HOLD, 16'h03e8, 16'h0030, 0);
            for (int i = 0; i < 48; i++) chk("mv_word", rdq[i], 16'h1000 + 16'(i));
        end
        for (int i = 0; i < 9; i++) begin
            rd(ta[i], tq[i]);
            chk("rd_exc", 16'(exc), 16'(te[i]));
        end
        $display("t_read done");
    endtask
    task automatic t_func();
        logic [7:0] fl [5] = '{FN_EXC_STAT, FN_DIAG, FN_EV_CNT, FN_EV_LOG, FN_SLAVE_ID};
        for (int s = 0; s < 2; s++) begin
            serial_line = s[0];
            for (int i = 0; i < 5; i++) begin
                xact(fl[i], 16'h0000, 16'h0001, 0);
                chk("diag_exc", 16'(exc), s ? 16'(EXC_NONE) : 16'(EXC_FUNC));
                chk("diag_flag", 16'(rsp_diag), 16'(s));
            end
        end
        serial_line = 1'b0;
        rd(16'h0000, 16'h0000);
        xact(8'h05, 16'h07d0, 16'h0001, 0);
        chk("bad_code", 16'(exc), 16'(EXC_FUNC));
        $display("t_func done");
    endtask
    task automatic t_write();
        wr(FN_WR_ONE, 16'h07db, 16'h1234, 16'h0000, 1, EXC_NONE);
        wr(FN_WR_MANY, 16'h07dc, 16'habcd, 16'h0000, 1, EXC_NONE);
        rd(16'h07db, 16'h0002);
        chk("plain0", rdq[0], 16'h1234);
        chk("plain1", rdq[1], 16'habcd);
        wr(FN_WR_ONE, 16'h07d3, 16'h0055, 16'h0000, 1, EXC_ADDR);
        rd(16'h07d3, 16'h0001);
        chk("cid_kept", rdq[0], 16'h0000);
        wr(FN_WR_ONE, 16'h07d2, 16'h5a5b, 16'h0000, 1, EXC_NONE);
        chk("priv_bad", 16'(priv_ok), 16'h0000);
        wr(FN_WR_ONE, 16'h07d2, 16'h5a5a, 16'h0000, 1, EXC_NONE);
        chk("priv_good", 16'(priv_ok), 16'h0001);
        rd(16'h07d2, 16'h0001);
        chk("pw_read", rdq[0], 16'h0000);
        wr(FN_WR_ONE, 16'h07d3, 16'h0055, 16'h0000, 1, EXC_NONE);
        rd(16'h07d3, 16'h0001);
        chk("cid_word", rdq[0], 16'h0055);
        wr(FN_WR_ONE, 16'h03fa, 16'h0001, 16'h0000, 1, EXC_ADDR);
        wr(FN_WR_MANY, 16'h03f8, 16'h0000, 16'h0001, 2, EXC_ADDR);
        wr(FN_WR_MANY, 16'h0400, 16'h0000, 16'h0001, 2, EXC_ADDR);
        wr(FN_WR_MANY, 16'h03fa, 16'hbeef, 16'hcafe, 2, EXC_NONE);
        rd(16'h03f8, 16'h0004);
        chk("sa1_kept", rdq[0], 16'h1010);
        chk("sa2_hi", rdq[2], 16'hbeef);
        chk("sa2_lo", rdq[3], 16'hcafe);
        xact(FN_WR_MANY, 16'h07db, 16'h007c, 0);
        chk("wr_qty", 16'(exc), 16'(EXC_VALUE));
        wr(FN_WR_ONE, 16'h07d0, 16'h0100, 16'h0000, 1, EXC_NONE);
        rd(16'h0101, 16'h0001);
        chk("moved_rd", rdq[0], 16'h1001);
        rd(16'h03e9, 16'h0001);
        chk("old_base", 16'(exc), 16'(EXC_ADDR));
        $display("t_write done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(negedge sys_clk);
        chk("ready_rst", 16'(req_ready), 16'h0000);
        chk("priv_rst", 16'(priv_ok), 16'h0000);
        rst_b = 1'b1;
        @(negedge sys_clk);
        chk("ready_up", 16'(req_ready), 16'h0001);
        @(negedge sys_clk);
        t_read();
        t_func();
        t_write();
        end_sim();
    end
endmodule
`default_nettype wire
